/* File: core/cmp_dev.sv */
// sensor end: i2c slave, command register, measurement and coil sequencing.
// assumes scl and sda reach it asynchronously; axis inputs are on MCLK.
module cmp_dev #(
  parameter int         CONV_CYCLES = cmp_pkg::CONV_CYC,
  parameter logic [1:0] ADDR_SEL    = 2'h0
) (
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  cmp_i2c_if.slave         BUS,
  input  wire logic [11:0] X_DATA,
  input  wire logic [11:0] Y_DATA,
  output logic             ANALOG_ON,
  output logic             COIL_SET,
  output logic             COIL_RESET
);
  import cmp_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_ADDR  = 3'h1,
    S_WDATA = 3'h2,
    S_SACK  = 3'h3,
    S_RDATA = 3'h4,
    S_MACK  = 3'h5
  } cmp_link_t;

  typedef enum logic [1:0] {
    P_SLEEP = 2'h0,
    P_MEAS  = 2'h1,
    P_COIL  = 2'h2
  } cmp_pwr_t;

  cmp_link_t         lstate;
  cmp_pwr_t          pstate;
  logic              scl_s;
  logic              sda_s;
  logic              scl_d;
  logic              sda_d;
  logic [3:0]        cnt;
  logic [7:0]        shreg;
  logic [7:0]        oreg;
  logic              rd_mode;
  logic              first_byte;
  logic              mack;
  logic [2:0]        ptr;
  logic [2:0]        ctrl;
  logic              coil_seen;
  logic [11:0]       x_val;
  logic [11:0]       y_val;
  logic [DEV_TW-1:0] tmr;

  //////////////////////////////////////////////////////////////////////////
  // bus sampling and condition detection
  cmp_sync u_scl (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .d     (BUS.scl),
    .q     (scl_s)
  );

  cmp_sync u_sda (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .d     (BUS.sda),
    .q     (sda_s)
  );

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  wire byte_end = scl_fall & (cnt == 4'h8);
  wire addr_hit = shreg[7:1] == {ADDR_HI, ADDR_SEL, 1'b0};
  wire [2:0] ptr_inc = (ptr == PTR_YL) ? PTR_CTRL : ptr + 3'h1;
  wire wr_ctrl  = (lstate == S_WDATA) & byte_end & ~first_byte & (ptr == PTR_CTRL);

  // unused upper nibble of each axis high byte reads as zero
  wire [7:0] rd_byte = (ptr == PTR_CTRL) ? {5'h00, ctrl} :
                       (ptr == PTR_XH)   ? {4'h0, x_val[11:8]} :
                       (ptr == PTR_XL)   ? x_val[7:0] :
                       (ptr == PTR_YH)   ? {4'h0, y_val[11:8]} :
                       (ptr == PTR_YL)   ? y_val[7:0] : 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // link state machine; data changes only after scl falls
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lstate     <= S_IDLE;
      cnt        <= 4'h0;
      shreg      <= 8'h00;
      oreg       <= 8'h00;
      rd_mode    <= 1'b0;
      first_byte <= 1'b0;
      mack       <= 1'b0;
      ptr        <= PTR_CTRL;
      BUS.sda_s_oe <= 1'b0;
    end else if (start_c) begin
      lstate       <= S_ADDR;
      cnt          <= 4'h0;
      BUS.sda_s_oe <= 1'b0;
    end else if (stop_c) begin
      lstate       <= S_IDLE;
      BUS.sda_s_oe <= 1'b0;
    end else if (scl_rise) begin
      unique case (lstate)
        S_ADDR, S_WDATA: begin
          shreg <= {shreg[6:0], sda_s};
          cnt   <= cnt + 4'h1;
        end
        S_RDATA: cnt <= cnt + 4'h1;
        S_MACK: begin
          mack <= ~sda_s;
          if (!sda_s) begin
            ptr <= ptr_inc;
          end
        end
        S_IDLE, S_SACK: begin
        end
        default: lstate <= S_IDLE;
      endcase
    end else if (scl_fall) begin
      unique case (lstate)
        S_ADDR: begin
          if (byte_end && addr_hit) begin
            rd_mode      <= shreg[0];
            first_byte   <= 1'b1;
            BUS.sda_s_oe <= 1'b1;
            lstate       <= S_SACK;
          end else if (byte_end) begin
            lstate <= S_IDLE;
          end
        end
        S_WDATA: begin
          if (byte_end) begin
            if (first_byte) begin
              ptr <= shreg[2:0];
            end
            first_byte   <= 1'b0;
            BUS.sda_s_oe <= 1'b1;
            lstate       <= S_SACK;
          end
        end
        S_SACK: begin
          cnt <= 4'h0;
          if (rd_mode) begin
            oreg         <= rd_byte;
            BUS.sda_s_oe <= ~rd_byte[7];
            lstate       <= S_RDATA;
          end else begin
            BUS.sda_s_oe <= 1'b0;
            lstate       <= S_WDATA;
          end
        end
        S_RDATA: begin
          if (byte_end) begin
            BUS.sda_s_oe <= 1'b0;
            lstate       <= S_MACK;
          end else begin
            oreg         <= {oreg[6:0], 1'b0};
            BUS.sda_s_oe <= ~oreg[6];
          end
        end
        S_MACK: begin
          cnt <= 4'h0;
          if (mack) begin
            oreg         <= rd_byte;
            BUS.sda_s_oe <= ~rd_byte[7];
            lstate       <= S_RDATA;
          end else begin
            lstate <= S_IDLE;
          end
        end
        S_IDLE: begin
        end
        default: lstate <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power sequencing; a command during an action is ignored, so no
  // software set can meet a hardware clear in the same cycle
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pstate     <= P_SLEEP;
      ctrl       <= 3'h0;
      coil_seen  <= 1'b0;
      x_val      <= 12'h000;
      y_val      <= 12'h000;
      tmr        <= '0;
      ANALOG_ON  <= 1'b0;
      COIL_SET   <= 1'b0;
      COIL_RESET <= 1'b0;
    end else begin
      unique case (pstate)
        P_SLEEP: begin
          if (wr_ctrl && shreg[BIT_SET]) begin
            ctrl[BIT_SET] <= 1'b1;
            coil_seen     <= 1'b1;
            COIL_SET      <= 1'b1;
            ANALOG_ON     <= 1'b1;
            tmr           <= DEV_TW'(PULSE_CYC);
            pstate        <= P_COIL;
          end else if (wr_ctrl && shreg[BIT_RST] && coil_seen) begin
            ctrl[BIT_RST] <= 1'b1;
            COIL_RESET    <= 1'b1;
            ANALOG_ON     <= 1'b1;
            tmr           <= DEV_TW'(PULSE_CYC);
            pstate        <= P_COIL;
          end else if (wr_ctrl && shreg[BIT_TM]) begin
            ctrl[BIT_TM] <= 1'b1;
            ANALOG_ON    <= 1'b1;
            tmr          <= DEV_TW'(CONV_CYCLES);
            pstate       <= P_MEAS;
          end
        end
        P_MEAS: begin
          tmr <= tmr - 1'b1;
          if (tmr == DEV_TW'(1)) begin
            x_val        <= X_DATA;
            y_val        <= Y_DATA;
            ctrl[BIT_TM] <= 1'b0;
            ANALOG_ON    <= 1'b0;
            pstate       <= P_SLEEP;
          end
        end
        P_COIL: begin
          tmr <= tmr - 1'b1;
          if (tmr == DEV_TW'(1)) begin
            ctrl[BIT_SET] <= 1'b0;
            ctrl[BIT_RST] <= 1'b0;
            COIL_SET      <= 1'b0;
            COIL_RESET    <= 1'b0;
            ANALOG_ON     <= 1'b0;
            pstate        <= P_SLEEP;
          end
        end
        default: pstate <= P_SLEEP;
      endcase
    end
  end
endmodule : cmp_dev

/* File: core/cmp_host.sv */
// controller end: apb register slave driving an i2c master toward the sensor.
// assumes an apb master on MCLK; scl is made here from MCLK by a divider.
module cmp_host #(
  parameter int         PWRON_CYCLES  = cmp_pkg::PWRON_CYC,
  parameter int         MEAS_CYCLES   = cmp_pkg::MEAS_CYC,
  parameter int         SETTLE_CYCLES = cmp_pkg::SETTLE_CYC,
  parameter logic [1:0] DEV_SEL       = 2'h0
) (
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  cmp_i2c_if.master        BUS
);
  import cmp_pkg::*;

  typedef enum logic [3:0] {
    O_IDLE = 4'h0, O_WAIT = 4'h1, O_START = 4'h2, O_ADDRW = 4'h3, O_PTR = 4'h4,
    O_DATA = 4'h5, O_RSTRT = 4'h6, O_ADDRR = 4'h7, O_READ = 4'h8, O_STOP = 4'h9
  } cmp_op_t;

  typedef enum logic [1:0] {
    C_NONE = 2'h0, C_SET = 2'h1, C_RST = 2'h2
  } cmp_coil_t;

  cmp_op_t            ostate;
  cmp_coil_t          last_coil;
  logic               sda_s;
  logic [3:0]         qdiv;
  logic [1:0]         q;
  logic [3:0]         bitn;
  logic [7:0]         txb;
  logic [7:0]         rxb;
  logic               ack_ok;
  logic [2:0]         rcnt;
  logic               op_rd;
  logic [2:0]         op_cnt;
  logic [7:0]         op_ptr;
  logic [7:0]         op_dat;
  logic [31:0]        cmd;
  logic               nack;
  logic               refused;
  logic [HOST_TW-1:0] hold;
  logic [7:0]         rbuf [5];

  cmp_sync u_sda (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .d     (BUS.sda),
    .q     (sda_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, answer in the access cycle
  wire       busy   = ostate != O_IDLE;
  wire       setup  = PSEL & ~PENABLE;
  wire       hit    = (PADDR == A_CMD) | (PADDR == A_STAT) | (PADDR == A_RD0) | (PADDR == A_RD1);
  wire       cmd_wr = PSEL & PENABLE & PREADY & PWRITE & (PADDR == A_CMD);
  wire       w_rd   = PWDATA[F_RD];
  wire [2:0] w_cnt  = PWDATA[F_CNT +: 3];
  wire [7:0] w_dat  = PWDATA[F_DAT +: 8];
  wire       w_set  = ~w_rd & w_dat[BIT_SET];
  wire       w_rst  = ~w_rd & w_dat[BIT_RST] & ~w_dat[BIT_SET];
  wire       bad_c  = (w_set & (last_coil == C_SET)) | (w_rst & (last_coil != C_SET));
  wire       bad_n  = w_rd & ((w_cnt == 3'h0) | (w_cnt > RD_MAX));
  wire       refuse = busy | bad_c | bad_n;
  wire       accept = cmd_wr & ~refuse;
  wire [31:0] rd_word = (PADDR == A_CMD)  ? cmd :
                        (PADDR == A_STAT) ? {29'h0, refused, nack, busy} :
                        (PADDR == A_RD0)  ? {rbuf[3], rbuf[2], rbuf[1], rbuf[0]} :
                        (PADDR == A_RD1)  ? {24'h0, rbuf[4]} : 32'h0;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
      cmd     <= 32'h0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & ~hit;
      PRDATA  <= setup ? rd_word : 32'h0;
      if (accept) begin
        cmd <= PWDATA;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // quarter-bit enable and engine
  wire tick    = qdiv == 4'(QTR_CYC - 1);
  wire in_byte = (ostate == O_ADDRW) | (ostate == O_PTR) | (ostate == O_DATA) |
                 (ostate == O_ADDRR) | (ostate == O_READ);
  wire in_cond = (ostate == O_START) | (ostate == O_RSTRT) | (ostate == O_STOP);
  wire ack_bit = bitn == 4'h8;
  wire last_rd = rcnt == op_cnt - 3'h1;
  wire stop_end = tick & (q == 2'h3) & (ostate == O_STOP);

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      qdiv <= 4'h0;
    end else begin
      qdiv <= tick ? 4'h0 : qdiv + 4'h1;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ostate <= O_IDLE;
      q      <= 2'h0;
      bitn   <= 4'h0;
      txb    <= 8'h00;
      rxb    <= 8'h00;
      ack_ok <= 1'b0;
      rcnt   <= 3'h0;
      op_rd  <= 1'b0;
      op_cnt <= 3'h0;
      op_ptr <= 8'h00;
      op_dat <= 8'h00;
      nack    <= 1'b0;
      refused <= 1'b0;
      BUS.scl      <= 1'b1;
      BUS.sda_m_oe <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        rbuf[i] <= 8'h00;
      end
    end else if (cmd_wr) begin
      refused <= refuse;
      if (!refuse) begin
        op_rd  <= w_rd;
        op_cnt <= w_cnt;
        op_ptr <= PWDATA[F_PTR +: 8];
        op_dat <= w_dat;
        rcnt   <= 3'h0;
        nack   <= 1'b0;
        ostate <= O_WAIT;
      end
    end else if (ostate == O_WAIT) begin
      if (tick && hold == '0) begin
        ostate <= O_START;
      end
    end else if (tick && (in_byte || in_cond)) begin
      q <= q + 2'h1;
      unique case (q)
        2'h0: begin
          if (in_cond) begin
            BUS.sda_m_oe <= ostate == O_STOP;
          end else if (ack_bit) begin
            BUS.sda_m_oe <= (ostate == O_READ) & ~last_rd;
          end else begin
            BUS.sda_m_oe <= (ostate != O_READ) & ~txb[7];
          end
        end
        2'h1: BUS.scl <= 1'b1;
        2'h2: begin
          if (in_cond) begin
            BUS.sda_m_oe <= ostate != O_STOP;
          end else if (ack_bit) begin
            ack_ok <= ~sda_s;
          end else begin
            rxb <= {rxb[6:0], sda_s};
          end
        end
        2'h3: begin
          if (ostate != O_STOP) begin
            BUS.scl <= 1'b0;
          end
          if (in_byte && !ack_bit) begin
            bitn <= bitn + 4'h1;
            txb  <= {txb[6:0], 1'b0};
          end else begin
            bitn <= 4'h0;
            unique case (ostate)
              O_START: begin
                txb    <= {ADDR_HI, DEV_SEL, 2'b00};
                ostate <= O_ADDRW;
              end
              O_RSTRT: begin
                txb    <= {ADDR_HI, DEV_SEL, 2'b01};
                ostate <= O_ADDRR;
              end
              O_ADDRW: begin
                nack   <= ~ack_ok;
                txb    <= op_rd ? op_ptr : 8'h00;
                ostate <= ack_ok ? O_PTR : O_STOP;
              end
              O_PTR: begin
                nack   <= ~ack_ok;
                txb    <= op_dat;
                ostate <= !ack_ok ? O_STOP : op_rd ? O_RSTRT : O_DATA;
              end
              O_DATA: begin
                nack   <= ~ack_ok;
                ostate <= O_STOP;
              end
              O_ADDRR: begin
                nack   <= ~ack_ok;
                ostate <= ack_ok ? O_READ : O_STOP;
              end
              O_READ: begin
                rbuf[rcnt] <= rxb;
                rcnt       <= rcnt + 3'h1;
                ostate     <= last_rd ? O_STOP : O_READ;
              end
              O_STOP: ostate <= O_IDLE;
              default: ostate <= O_IDLE;
            endcase
          end
        end
        default: q <= 2'h0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // hold-off after power-on and after each acked write carrying a set, measure or reset bit
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold      <= HOST_TW'(PWRON_CYCLES);
      last_coil <= C_NONE;
    end else if (stop_end && !op_rd && !nack) begin
      if (op_dat[BIT_SET]) begin
        hold      <= HOST_TW'(SETTLE_CYCLES);
        last_coil <= C_SET;
      end else if (op_dat[BIT_TM]) begin
        hold <= HOST_TW'(MEAS_CYCLES);
      end else if (op_dat[BIT_RST]) begin
        hold      <= HOST_TW'(COIL_CYC);
        last_coil <= C_RST;
      end
    end else if (hold != '0) begin
      hold <= hold - 1'b1;
    end
  end
endmodule : cmp_host

/* File: core/cmp_i2c_if.sv */
// two-wire link between the controller and the sensor.
// assumes open-drain sda with a pull-up: the line is low while any end drives.
interface cmp_i2c_if;
  logic scl;
  logic sda_m_oe;
  logic sda_s_oe;
  logic sda;

  assign sda = ~(sda_m_oe | sda_s_oe);

  modport master (output scl, output sda_m_oe, input sda);
  modport slave  (input scl, output sda_s_oe, input sda);
endinterface : cmp_i2c_if

/* File: core/cmp_pkg.sv */
// constants shared by both ends of the compass sensor link.
// assumes a single 20 MHz clock on each end and the wired-and bus in cmp_i2c_if.
//
// Behaviour
// - device powers down itself after acquisition
// - write with bit 0 set starts measurement
// - slave address 0110xx0, xx fixed per part
// - device acks address and written bytes
// - master always writes register address zero (reads here send op_ptr instead)
// - master waits 5 ms before reading result
// - take_measurement_bit clears when data ready
// - sleep: analog off, link alive, data kept
// - read starts with pointer write, five addresses
// - pointer advances after each acked read byte
// - read order: control, X high/low, Y high/low
// - master ends read with nack then stop
// - bit 1 pulses SET, bit 2 pulses RESET
// - SET and RESET together: SET only
// - master waits 50 us after coil command
// - coil bit clears when pulse completes
// - master alternates SET and RESET commands
// - RESET before first SET is ignored
// - master waits 5 ms from SET to RESET
// - master waits 10 ms after power-on
// - power-on clears register and pointer
// - read call has direction bit high, acked
// - axis bytes carry 12 bits, upper zero
package cmp_pkg;

  localparam int         CLK_NS   = 50;
  localparam logic [3:0] ADDR_HI  = 4'h6;
  localparam logic [2:0] PTR_CTRL = 3'h0;
  localparam logic [2:0] PTR_XH   = 3'h1;
  localparam logic [2:0] PTR_XL   = 3'h2;
  localparam logic [2:0] PTR_YH   = 3'h3;
  localparam logic [2:0] PTR_YL   = 3'h4;
  localparam int         BIT_TM   = 0;
  localparam int         BIT_SET  = 1;
  localparam int         BIT_RST  = 2;

  //////////////////////////////////////////////////////////////////////////
  // timing; least times round up, device durations round down
  localparam int T_CONV_NS   = 4_000_000;
  localparam int CONV_CYC    = T_CONV_NS / CLK_NS;
  localparam int T_PULSE_NS  = 1_000;
  localparam int PULSE_CYC   = T_PULSE_NS / CLK_NS;
  localparam int T_MEAS_NS   = 5_000_000;
  localparam int MEAS_CYC    = (T_MEAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_COIL_NS   = 50_000;
  localparam int COIL_CYC    = (T_COIL_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_SETTLE_NS = 5_000_000;
  localparam int SETTLE_CYC  = (T_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_PWRON_NS  = 10_000_000;
  localparam int PWRON_CYC   = (T_PWRON_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_SCL_NS    = 2_600;
  localparam int QTR_CYC     = (T_SCL_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam int DEV_TW      = 17;
  localparam int HOST_TW     = 24;

  //////////////////////////////////////////////////////////////////////////
  // host register map over apb
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_RD0  = 8'h08;
  localparam logic [7:0] A_RD1  = 8'h0C;
  localparam int         F_RD   = 0;
  localparam int         F_CNT  = 1;
  localparam int         F_PTR  = 8;
  localparam int         F_DAT  = 16;
  localparam logic [2:0] RD_MAX = 3'h5;

endpackage : cmp_pkg

/* File: core/cmp_sync.sv */
// two-stage synchroniser for one asynchronous level.
// assumes the idle level of the line is high.
module cmp_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b1;
      q    <= 1'b1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : cmp_sync

/* File: dv/cmp_monitor.sv */
// checker for the compass link: coil and power sequencing.
// assumes one MCLK domain, instanced beside the bus interface.
module cmp_monitor
  import cmp_pkg::*;
#(
  parameter int CONV_CYCLES   = 50,
  parameter int SETTLE_CYCLES = 100,
  parameter int PWRON_CYCLES  = 100
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic scl,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic sda,
  input wire logic ANALOG_ON,
  input wire logic COIL_SET,
  input wire logic COIL_RESET
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  int unsigned pulse_n;
  int unsigned on_n;
  int unsigned since_set;
  int unsigned up_n;
  logic [1:0]  last_coil;
  wire         coil_on = COIL_SET | COIL_RESET;

  ////////////////////////////////////////
  // saturating so a long idle cannot wrap
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pulse_n   <= 0;
      on_n      <= 0;
      since_set <= 0;
      up_n      <= 0;
      last_coil <= 2'h0;
    end else begin
      up_n      <= (up_n < 32'hFFFFF) ? up_n + 1 : up_n;
      pulse_n   <= coil_on ? pulse_n + 1 : 0;
      on_n      <= ANALOG_ON ? on_n + 1 : 0;
      since_set <= COIL_SET ? 0 : (since_set < 32'hFFFFF ? since_set + 1 : since_set);
      if (COIL_SET)
        last_coil <= 2'h1;
      else if (COIL_RESET)
        last_coil <= 2'h2;
    end
  end

  ////////////////////////////////////////
  sequence s_coil_end;
    $fell(COIL_SET) || $fell(COIL_RESET);
  endsequence

  sequence s_reset_start;
    $rose(COIL_RESET);
  endsequence

  // host pulls data low while the clock is high: start or repeated start
  sequence s_start;
    scl && $rose(sda_m_oe);
  endsequence

  sequence s_stop;
    scl && $fell(sda_m_oe);
  endsequence

  chk_pulse_len: assert property (s_coil_end |-> pulse_n == PULSE_CYC)
    else $error("coil pulse length wrong");
  chk_coil_exclusive: assert property (!(COIL_SET && COIL_RESET))
    else $error("both coil drives active");
  chk_coil_powered: assert property (coil_on && $past(coil_on) |-> ANALOG_ON)
    else $error("coil pulse without analog power");
  chk_sleep_bound: assert property (ANALOG_ON |-> on_n <= CONV_CYCLES + 2)
    else $error("analog section stays on too long");
  chk_set_alternate: assert property ($rose(COIL_SET) |-> last_coil != 2'h1)
    else $error("set follows set");
  chk_reset_after_set: assert property (s_reset_start |-> last_coil == 2'h1)
    else $error("reset without preceding set");
  chk_settle_gap: assert property (s_reset_start |-> since_set >= SETTLE_CYCLES)
    else $error("reset too soon after set");
  chk_ack_clk_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("sensor moves data while clock high");
  chk_power_on_wait: assert property (s_start |-> up_n >= PWRON_CYCLES)
    else $error("transfer starts before power-on wait");
  chk_start_asleep: assert property (s_start |-> !ANALOG_ON)
    else $error("transfer starts while sensor busy");
  chk_stop_released: assert property (s_stop |-> sda)
    else $error("sensor holds data line at stop");
endmodule : cmp_monitor

/* File: dv/compass_i2c_measure_setreset_bench.sv */
// bench joining controller and sensor over the two-wire link.
// assumes short counts: power-on 100, measure hold 200, conversion 50.
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module compass_i2c_measure_setreset_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import cmp_pkg::*;

  localparam int         PWRON_N  = 100;
  localparam int         MEAS_N   = 200;
  localparam int         CONV_N   = 50;
  localparam int         SETTLE_N = 100;
  localparam logic [1:0] SEL_N    = 2'h2;

  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        noted = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [11:0] x_in = 12'h000;
  logic [11:0] y_in = 12'h000;
  wire  [31:0] prdata;
  wire         pready, pslverr, analog_on, coil_set, coil_reset;
  logic [32:0] exp_q[$];
  int          failures = 0;
  int          cmp_count = 0;
  int          n_set = 0;
  int          n_rst = 0;

  cmp_i2c_if bus_if();
  cmp_host #(.PWRON_CYCLES(PWRON_N), .MEAS_CYCLES(MEAS_N), .SETTLE_CYCLES(SETTLE_N),
    .DEV_SEL(SEL_N))
    cmp_host_inst (.MCLK(mclk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BUS(bus_if));
  cmp_dev #(.CONV_CYCLES(CONV_N), .ADDR_SEL(SEL_N))
    cmp_dev_inst (.MCLK(mclk), .RESET_N(reset_n), .BUS(bus_if), .X_DATA(x_in),
    .Y_DATA(y_in), .ANALOG_ON(analog_on), .COIL_SET(coil_set), .COIL_RESET(coil_reset));
  cmp_monitor #(.CONV_CYCLES(CONV_N), .SETTLE_CYCLES(SETTLE_N), .PWRON_CYCLES(PWRON_N))
    cmp_monitor_inst (.MCLK(mclk), .RESET_N(reset_n), .scl(bus_if.scl),
    .sda_m_oe(bus_if.sda_m_oe), .sda_s_oe(bus_if.sda_s_oe), .sda(bus_if.sda),
    .ANALOG_ON(analog_on), .COIL_SET(coil_set), .COIL_RESET(coil_reset));

  always #25 mclk = ~mclk;
  always @(posedge coil_set) n_set++;
  always @(posedge coil_reset) n_rst++;

  ////////////////////////////////////////
  // only noted reads are judged; status polls pass unchecked
  always @(posedge mclk) begin
    if (psel && penable && pready && noted)
      `CMP({pslverr, prdata}, exp_q.pop_front())
  end

  task automatic conclude();
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic n, output logic [31:0] r);
    int k;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    noted   <= n;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      failures++;
      conclude();
    end
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    noted   <= 1'b0;
  endtask : apb

  task automatic rd_exp(input logic [7:0] a, input logic [32:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0, 1'b1, r);
  endtask : rd_exp

  // a link transfer spans up to some 3900 cycles (five-byte read), so the 3000-poll bound is generous
  task automatic cmd(input logic [31:0] d, input logic [32:0] st);
    logic [31:0] r;
    int k;
    apb(1'b1, A_CMD, d, 1'b0, r);
    k = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0, 1'b0, r);
      k++;
    end while (r[0] !== 1'b0 && k < 3000);
    if (r[0] !== 1'b0) begin
      failures++;
      conclude();
    end
    rd_exp(A_STAT, st);
  endtask : cmd

  ////////////////////////////////////////
  initial begin
    void'($urandom(35));
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    x_in    <= 12'($urandom());
    y_in    <= 12'($urandom());
    rd_exp(A_STAT, 33'h0);
    rd_exp(8'h10, {1'b1, 32'h0});
    cmd(32'h0004_0002, 33'h4);
    `CMP(n_rst, 0)
    cmd(32'h0006_0002, 33'h0);
    `CMP(n_set, 1)
    `CMP(n_rst, 0)
    cmd(32'h0002_0002, 33'h4);
    cmd(32'h0004_0002, 33'h0);
    `CMP(n_rst, 1)
    cmd(32'h0001_0002, 33'h0);
    cmd(32'h0000_000B, 33'h0);
    rd_exp(A_RD0, {1'b0, 4'h0, y_in[11:8], x_in[7:0], 4'h0, x_in[11:8], 8'h00});
    rd_exp(A_RD1, {1'b0, 24'h0, y_in[7:0]});
    cmd(32'h0000_0109, 33'h0);
    rd_exp(A_RD0, {1'b0, y_in[7:0], 4'h0, y_in[11:8], x_in[7:0], 4'h0, x_in[11:8]});
    for (int c = 0; c < 2; c++) begin
      cmd(c ? 32'h0000_000D : 32'h0000_0001, 33'h4);
    end
    conclude();
  end
endmodule : compass_i2c_measure_setreset_bench
